// ==== logic/ext_irq_enable_priority_2.sv ====
/*
  Second extended interrupt enable and priority pair, with the per-source
  gating and preemption check for the second uart and bus-power sources.
  Assumes the core drives the register bus and service begin/end strobes
  synchronously on clk_in; request lines come from on-chip logic.
*/
`timescale 1ns/100ps
`include "ext_irq_two_map.svh"

module ext_irq_enable_priority_2
  import ext_irq_two_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire sfr_req_t   sfr_in,
  input  wire logic       uart_b_req_in,
  input  wire logic       bus_power_req_in,
  input  wire logic       svc_begin_in,
  input  wire logic       svc_begin_high_in,
  input  wire logic       svc_end_in,
  output logic [7:0]      sfr_rdata_out,
  output logic            uart_b_irq_enable_out,
  output logic            bus_power_irq_enable_out,
  output logic            uart_b_irq_priority_out,
  output logic            bus_power_irq_priority_out,
  output logic            take_high_out,
  output logic            take_low_out
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  enable_r;
  logic [7:0]  enable_nxt;
  logic [7:0]  priority_r;
  logic [7:0]  priority_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  always_comb
  begin
    enable_nxt   = enable_r;
    priority_nxt = priority_r;
    rdata_nxt    = rdata_r;
    if (sfr_in.wr && sfr_in.addr == `ENABLE_TWO_ADDR)
    begin
      enable_nxt = sfr_in.wdata;
    end
    if (sfr_in.wr && sfr_in.addr == `PRIORITY_TWO_ADDR)
    begin
      priority_nxt = sfr_in.wdata & `PRIORITY_TWO_MASK;
    end
    if (sfr_in.rd)
    begin
      unique case (sfr_in.addr)
        `ENABLE_TWO_ADDR:   rdata_nxt = enable_r;
        `PRIORITY_TWO_ADDR: rdata_nxt = priority_r & `PRIORITY_TWO_MASK;
        default:            rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      enable_r   <= `ENABLE_TWO_RESET;
      priority_r <= `PRIORITY_TWO_RESET;
      rdata_r    <= 8'h00;
    end
    else
    begin
      enable_r   <= enable_nxt;
      priority_r <= priority_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Service level tracking and preemption
  svc_level_t  level_r;
  svc_level_t  level_nxt;
  logic        was_low_r;
  logic        was_low_nxt;
  logic        high_r;
  logic        high_nxt;
  logic        low_r;
  logic        low_nxt;
  logic        uart_on;
  logic        bus_on;
  logic        any_high;
  logic        any_low;

  always_comb
  begin
    uart_on  = uart_b_req_in && enable_r[`UART_B_BIT];
    bus_on   = bus_power_req_in && enable_r[`BUS_POWER_BIT];
    any_high = (uart_on && priority_r[`UART_B_BIT])
            || (bus_on && priority_r[`BUS_POWER_BIT]);
    any_low  = (uart_on && !priority_r[`UART_B_BIT])
            || (bus_on && !priority_r[`BUS_POWER_BIT]);
    level_nxt   = level_r;
    was_low_nxt = was_low_r;
    unique case (level_r)
      LVL_IDLE:
      begin
        if (svc_begin_in)
        begin
          level_nxt = svc_begin_high_in ? LVL_HIGH : LVL_LOW;
        end
      end
      LVL_LOW:
      begin
        if (svc_begin_in && svc_begin_high_in)
        begin
          level_nxt   = LVL_HIGH;
          was_low_nxt = 1'b1;
        end
        else if (svc_end_in)
        begin
          level_nxt = LVL_IDLE;
        end
      end
      LVL_HIGH:
      begin
        if (svc_end_in)
        begin
          level_nxt   = was_low_r ? LVL_LOW : LVL_IDLE;
          was_low_nxt = 1'b0;
        end
      end
      default:
      begin
        level_nxt   = LVL_IDLE;
        was_low_nxt = 1'b0;
      end
    endcase
    high_nxt = any_high && (level_r != LVL_HIGH);
    low_nxt  = any_low && !any_high && (level_r == LVL_IDLE);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      level_r   <= LVL_IDLE;
      was_low_r <= 1'b0;
      high_r    <= 1'b0;
      low_r     <= 1'b0;
    end
    else
    begin
      level_r   <= level_nxt;
      was_low_r <= was_low_nxt;
      high_r    <= high_nxt;
      low_r     <= low_nxt;
    end
  end

  assign sfr_rdata_out              = rdata_r;
  assign uart_b_irq_enable_out      = enable_r[`UART_B_BIT];
  assign bus_power_irq_enable_out   = enable_r[`BUS_POWER_BIT];
  assign uart_b_irq_priority_out    = priority_r[`UART_B_BIT];
  assign bus_power_irq_priority_out = priority_r[`BUS_POWER_BIT];
  assign take_high_out              = high_r;
  assign take_low_out               = low_r;

  ////////////////////////////////////////////////////////////////////////
  // Register bus checks
  enable_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.wr && sfr_in.addr == `ENABLE_TWO_ADDR |=> enable_r == $past(sfr_in.wdata))
    else $error("enable register did not take write");
  enable_reset_a: assert property (@(posedge clk_in)
    !rst_b_in |=> enable_r == 8'h00 && priority_r == 8'h00)
    else $error("registers not cleared by reset");
  uart_prio_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.wr && sfr_in.addr == `PRIORITY_TWO_ADDR |=>
    uart_b_irq_priority_out == $past(sfr_in.wdata[1]))
    else $error("uart priority bit wrong");
  bus_prio_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.wr && sfr_in.addr == `PRIORITY_TWO_ADDR |=>
    bus_power_irq_priority_out == $past(sfr_in.wdata[0]))
    else $error("bus power priority bit wrong");
  prio_unused_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.rd && sfr_in.addr == `PRIORITY_TWO_ADDR |=> sfr_rdata_out[7:2] == 6'h00)
    else $error("unused priority bits read nonzero");
  enable_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.rd && sfr_in.addr == `ENABLE_TWO_ADDR |=> sfr_rdata_out == $past(enable_r))
    else $error("enable register read back wrong");
  prio_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.rd && sfr_in.addr == `PRIORITY_TWO_ADDR |=>
    sfr_rdata_out[1:0] == $past(priority_r[1:0]))
    else $error("priority bits read back wrong");
  prio_write_mask_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sfr_in.wr && sfr_in.addr == `PRIORITY_TWO_ADDR |=> priority_r[7:2] == 6'h00)
    else $error("unused priority bits stored a write");
  enable_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(sfr_in.wr && sfr_in.addr == `ENABLE_TWO_ADDR) |=> $stable(enable_r))
    else $error("enable register changed without a write");

  ////////////////////////////////////////////////////////////////////////
  // Service level checks
  masked_uart_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !enable_r[1] && !enable_r[0] |=> !take_high_out && !take_low_out)
    else $error("masked source was taken");
  no_low_preempt_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    level_r != LVL_IDLE |=> !take_low_out)
    else $error("low request preempted service");
  high_preempt_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    level_r == LVL_LOW && uart_b_req_in && enable_r[1] && priority_r[1] |=> take_high_out)
    else $error("high request failed to preempt low");
  bus_high_take_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    level_r != LVL_HIGH && bus_power_req_in && enable_r[`BUS_POWER_BIT]
    && priority_r[`BUS_POWER_BIT] |=> take_high_out)
    else $error("high bus power request not taken");
  high_blocks_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    any_high |=> !take_low_out)
    else $error("low request offered while high pending");
  idle_low_take_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    level_r == LVL_IDLE && any_low && !any_high |=> take_low_out)
    else $error("idle low request not offered");
  high_level_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    level_r == LVL_HIGH |=> !take_high_out)
    else $error("request offered during high service");
endmodule

// ==== logic/ext_irq_two_map.svh ====
/*
  Offsets, field positions and reset values of the second extended
  interrupt enable and priority registers.
  Assumes an 8-bit special-function-register bus from the core.
*/
`ifndef EXT_IRQ_TWO_MAP_SVH
`define EXT_IRQ_TWO_MAP_SVH
`define ENABLE_TWO_ADDR      8'hE7
`define PRIORITY_TWO_ADDR    8'hF7
`define UART_B_BIT           1
`define BUS_POWER_BIT        0
`define ENABLE_TWO_RESET     8'h00
`define PRIORITY_TWO_RESET   8'h00
`define PRIORITY_TWO_MASK    8'h03
`endif

// ==== logic/ext_irq_two_pkg.sv ====
/*
  Types for the second extended interrupt enable and priority block.
  Assumes nothing of its surroundings.
*/
package ext_irq_two_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef enum logic [2:0] {
    LVL_IDLE = 3'b001,
    LVL_LOW  = 3'b010,
    LVL_HIGH = 3'b100
  } svc_level_t;
endpackage

// ==== test/core_svc_model.sv ====
/*
  Core service sequencing model: turns bench commands into strobes.
  Assumes commands change just after clk_in rises.
*/
`timescale 1ns/100ps
module core_svc_model
(
  input  wire logic clk_in,
  input  wire logic start_in,
  input  wire logic high_in,
  input  wire logic stop_in,
  output logic      svc_begin_out,
  output logic      svc_begin_high_out,
  output logic      svc_end_out
);
  always_ff @(posedge clk_in)
  begin
    svc_begin_out      <= start_in;
    svc_begin_high_out <= start_in & high_in;
    svc_end_out        <= stop_in;
  end
endmodule

// ==== test/tb.sv ====
/*
  Bench for the second extended interrupt enable and priority pair.
  Assumes core_svc_model drives the service strobes.
*/
`timescale 1ns/100ps
module tb;
  import ext_irq_two_pkg::*;
  logic       clk_in = 0, rst_b_in = 0, ureq = 0, breq = 0, st = 0, hi = 0, sp = 0;
  sfr_req_t   sfr = '0;
  logic       sb, sbh, se, th, tl, ue, be, up, bp;
  logic [7:0] rdata;
  int         num_errors = 0, check_count = 0;
  always #50 clk_in = ~clk_in;
  core_svc_model CORE (.clk_in(clk_in), .start_in(st), .high_in(hi), .stop_in(sp),
    .svc_begin_out(sb), .svc_begin_high_out(sbh), .svc_end_out(se));
  ext_irq_enable_priority_2 DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_in(sfr),
    .uart_b_req_in(ureq), .bus_power_req_in(breq), .svc_begin_in(sb),
    .svc_begin_high_in(sbh), .svc_end_in(se), .sfr_rdata_out(rdata),
    .uart_b_irq_enable_out(ue), .bus_power_irq_enable_out(be),
    .uart_b_irq_priority_out(up), .bus_power_irq_priority_out(bp),
    .take_high_out(th), .take_low_out(tl));
  ////////////////////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge clk_in);
    #10;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{1'b1, 1'b0, a, d};
    step(1);
    sfr = '0;
    step(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    step(1);
    sfr = '0;
    step(1);
    chk(rdata, exp);
  endtask
  task svc(input logic b, input logic h);
    st = b;
    hi = h;
    sp = ~b;
    step(1);
    st = 0;
    sp = 0;
    step(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task reset_check;
    chk({2'b00, ue, be, up, bp, th, tl}, 8'h00);
    rd(8'hE7, 8'h00);
    rd(8'hF7, 8'h00);
  endtask
  task enable_check;
    wr(8'hE7, 8'h02);
    chk({6'h00, ue, be}, 8'h02);
    rd(8'hE7, 8'h02);
    wr(8'hE7, 8'h01);
    wr(8'hE4, 8'hFF);
    chk({6'h00, ue, be}, 8'h01);
    rd(8'hE4, 8'h00);
  endtask
  task priority_check;
    wr(8'hF7, 8'hFE);
    chk({6'h00, up, bp}, 8'h02);
    rd(8'hF7, 8'h02);
    wr(8'hF7, 8'hFD);
    chk({6'h00, up, bp}, 8'h01);
    rd(8'hF7, 8'h01);
  endtask
  task preempt_check;
    wr(8'hE7, 8'h03);
    wr(8'hF7, 8'h02);
    breq = 1;
    step(2);
    chk({6'h00, th, tl}, 8'h01);
    svc(1'b1, 1'b0);
    ureq = 1;
    step(2);
    chk({6'h00, th, tl}, 8'h02);
    svc(1'b1, 1'b1);
    chk({6'h00, th, tl}, 8'h00);
    svc(1'b0, 1'b0);
    chk({6'h00, th, tl}, 8'h02);
    ureq = 0;
    svc(1'b0, 1'b0);
    chk({6'h00, th, tl}, 8'h01);
  endtask
  task mixed_check;
    wr(8'hF7, 8'h01);
    ureq = 1;
    breq = 1;
    step(2);
    chk({6'h00, th, tl}, 8'h02);
    svc(1'b1, 1'b1);
    chk({6'h00, th, tl}, 8'h00);
    svc(1'b0, 1'b0);
    chk({6'h00, th, tl}, 8'h02);
    breq = 0;
    step(2);
    chk({6'h00, th, tl}, 8'h01);
  endtask
  task reset_mid_check;
    wr(8'hE7, 8'h03);
    wr(8'hF7, 8'h03);
    ureq = 1;
    breq = 1;
    rst_b_in = 0;
    step(2);
    rst_b_in = 1;
    step(2);
    chk({2'b00, ue, be, up, bp, th, tl}, 8'h00);
    rd(8'hE7, 8'h00);
    ureq = 0;
    breq = 0;
  endtask
  task close_out;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    step(10);
    rst_b_in = 1;
    step(1);
    reset_check();
    enable_check();
    priority_check();
    preempt_check();
    mixed_check();
    reset_mid_check();
    close_out();
  end
endmodule
